// ===== verilog/wdtb_pkg.sv
// Shared constants and types of the watchdog timer block.
//
// Summary of operation
// - Counter advances on the 31 kHz low-frequency oscillator, about 1 ms base.
// - Reaching the selected period without a clear requests a device reset when neither in Sleep nor Idle.
// - Mode 11 keeps the watchdog active always, Sleep included, enable ignored.
// - Mode 10 keeps the watchdog active while awake, disabled in Sleep.
// - Mode 01 follows the software enable bit, awake or asleep.
// - Mode 00, or mode 01 with enable 0, holds the counter cleared.
// - Software enable is control bit 0, ignored in modes 1x and 00.
// - Period select bits 5..1 give prescale 32 times two to the code.
// - Period codes 10011 to 11111 act as the minimum 1:32 prescale.
// - After reset the period select is 01011, a 1:65536 two-second period.
// - Count clears on reset, clear instruction, Sleep change, oscillator fail, disable, start-up.
// - Entering Sleep clears the count; counting resumes if Sleep keeps it enabled.
// - After Sleep the count stays zero until the start-up timer completes.
// - Time-out in Sleep wakes without reset and records time-out and power-down flags.
// - Clock switches and divider changes leave the count unaffected.
// - Time-out in Idle wakes the device without reset and raises no interrupt.
package wdtb_pkg;

	// Oscillator and base interval.
	localparam int LFO_FREQ_HZ      = 31000;
	localparam int BASE_INTERVAL_US = 1000;
	localparam int PRESCALE_LOG2    = 5;
	localparam int CNT_MIN_W        = 24;

	// Register byte addresses.
	localparam logic [11:0] ADDR_CTRL     = 12'h000;
	localparam logic [11:0] ADDR_STATUS   = 12'h004;
	localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;
	localparam logic [11:0] ADDR_IRQ_MASK = 12'h00c;
	localparam logic [11:0] ADDR_COUNT    = 12'h010;

	// Control register layout.
	localparam int          CTRL_SWEN_BIT = 0;
	localparam int          CTRL_PS_LSB   = 1;
	localparam int          CTRL_PS_MSB   = 5;
	localparam logic [4:0]  PS_RESET      = 5'h0b;
	localparam logic [4:0]  PS_MAX        = 5'h12;
	localparam logic [7:0]  CTRL_RESET    = 8'h16;
	localparam logic [7:0]  CTRL_WR_MASK  = 8'h3f;

	// Status register layout.
	localparam int STAT_TIMEOUT_BIT = 0;
	localparam int STAT_PWRDN_BIT   = 1;
	localparam int STAT_ACTIVE_BIT  = 2;
	localparam int STAT_HOLD_BIT    = 3;
	localparam int STAT_MODE_LSB    = 4;

	// Interrupt status and mask layout.
	localparam int         IRQ_W           = 3;
	localparam int         IRQ_RESET_BIT   = 0;
	localparam int         IRQ_WAKE_BIT    = 1;
	localparam int         IRQ_OSCFAIL_BIT = 2;
	localparam logic [2:0] IRQ_MASK_RESET  = 3'h0;

	// Operating modes.
	localparam logic [1:0] MODE_OFF      = 2'h0;
	localparam logic [1:0] MODE_SOFTWARE = 2'h1;
	localparam logic [1:0] MODE_AWAKE    = 2'h2;
	localparam logic [1:0] MODE_ALWAYS   = 2'h3;

	// Counter states.
	typedef enum logic [2:0] {
		WDTB_OFF  = 3'b001,
		WDTB_RUN  = 3'b010,
		WDTB_HOLD = 3'b100
	} wdtb_state_t;

endpackage

// ===== verilog/wdtb_lfo_tick.sv
// Synchroniser and edge detector turning the oscillator input into tick pulses.
module wdtb_lfo_tick
(
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst,
	// Oscillator level.
	input  wire logic lfo_in,
	// One-cycle pulse per oscillator rising edge.
	output logic      tick
);

	typedef struct packed {
		logic meta;
		logic sync;
		logic prev;
		logic tick;
	} wdtb_tick_st_t;

	wdtb_tick_st_t s_q;
	wdtb_tick_st_t s_d;

	// The first stage feeds only the second stage.
	always_comb
	begin
		s_d      = s_q;
		s_d.meta = lfo_in;
		s_d.sync = s_q.meta;
		s_d.prev = s_q.sync;
		s_d.tick = s_q.sync & ~s_q.prev;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign tick = s_q.tick;

endmodule

// ===== verilog/wdtb_top.sv
// Watchdog timer block with APB register access and interrupt logic.
//
// Local design decisions: the APB interface to the registers and the register offsets.
module wdtb_top
#(
	parameter int CNT_W = 24
)
(
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rst,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Oscillator.
	input  wire logic        low_freq_internal_osc,
	// Configuration and CPU state.
	input  wire logic [1:0]  wdt_mode_cfg,
	input  wire logic        clear_watchdog_instr,
	input  wire logic        sleep_mode,
	input  wire logic        idle_mode,
	input  wire logic        osc_fail,
	input  wire logic        osc_startup_timer_running,
	// Results.
	output logic             device_reset_req,
	output logic             wake_req,
	output logic             timeout_flag,
	output logic             powerdown_flag,
	output logic             irq
);

	if (CNT_W < wdtb_pkg::CNT_MIN_W || CNT_W > 32)
	begin : g_check
		$error("Counter width must cover the longest period and fit the bus word.");
	end

	localparam int IRQ_LAST = wdtb_pkg::IRQ_W - 1;

	typedef struct packed {
		wdtb_pkg::wdtb_state_t             st;
		logic [7:0]                        ctrl;
		logic [CNT_W-1:0]                  cnt;
		logic                              sleep_prev;
		logic [wdtb_pkg::IRQ_W-1:0]        irq_stat;
		logic [wdtb_pkg::IRQ_W-1:0]        irq_mask;
		logic                              tflag;
		logic                              pflag;
		logic                              rst_req;
		logic                              wake;
		logic                              irq;
		logic                              pready;
		logic                              pslverr;
		logic [31:0]                       prdata;
	} wdtb_st_t;

	wdtb_st_t s_q;
	wdtb_st_t s_d;
	logic     tick;

	// Terminal count of the selected period.
	function automatic logic [CNT_W-1:0] wdtb_terminal(input logic [4:0] ps);
		logic [CNT_W-1:0] one;
		one = {{(CNT_W-1){1'b0}}, 1'b1};
		if (ps > wdtb_pkg::PS_MAX)
			return one << wdtb_pkg::PRESCALE_LOG2;
		else
			return one << (wdtb_pkg::PRESCALE_LOG2 + int'(ps));
	endfunction

	// Whether the counter may run in the present mode.
	function automatic logic wdtb_active(input logic [1:0] mode, input logic swen,
		input logic asleep);
		case (mode)
			wdtb_pkg::MODE_ALWAYS:   return 1'b1;
			wdtb_pkg::MODE_AWAKE:    return ~asleep;
			wdtb_pkg::MODE_SOFTWARE: return swen;
			default:                 return 1'b0;
		endcase
	endfunction

	// Address decode used by the error path.
	function automatic logic wdtb_mapped(input logic [11:0] addr);
		return (addr == wdtb_pkg::ADDR_CTRL) || (addr == wdtb_pkg::ADDR_STATUS) ||
			(addr == wdtb_pkg::ADDR_IRQ_STAT) || (addr == wdtb_pkg::ADDR_IRQ_MASK) ||
			(addr == wdtb_pkg::ADDR_COUNT);
	endfunction

	wdtb_lfo_tick u_tick
	(
		.clk    (clk),
		.rst    (rst),
		.lfo_in (low_freq_internal_osc),
		.tick   (tick)
	);

	always_comb
	begin
		logic             acc;
		logic             done;
		logic             active;
		logic             sleep_edge;
		logic             clr;
		logic             tout;
		logic [CNT_W-1:0] term;
		logic [31:0]      rd;
		logic [IRQ_LAST:0] ev;

		acc        = psel & penable;
		done       = acc & s_q.pready;
		active     = wdtb_active(wdt_mode_cfg, s_q.ctrl[wdtb_pkg::CTRL_SWEN_BIT], sleep_mode);
		sleep_edge = sleep_mode ^ s_q.sleep_prev;
		term       = wdtb_terminal(s_q.ctrl[wdtb_pkg::CTRL_PS_MSB:wdtb_pkg::CTRL_PS_LSB]);
		tout       = 1'b0;
		rd         = 32'h0000_0000;
		ev         = '0;
		clr        = 1'b0;

		s_d            = s_q;
		s_d.rst_req    = 1'b0;
		s_d.wake       = 1'b0;
		s_d.pready     = 1'b0;
		s_d.pslverr    = 1'b0;
		s_d.sleep_prev = sleep_mode;

		// Read data and error are prepared in the first access cycle.
		case (paddr)
			wdtb_pkg::ADDR_CTRL:
				rd = {24'h00_0000, s_q.ctrl & wdtb_pkg::CTRL_WR_MASK};
			wdtb_pkg::ADDR_STATUS:
			begin
				rd[wdtb_pkg::STAT_TIMEOUT_BIT] = s_q.tflag;
				rd[wdtb_pkg::STAT_PWRDN_BIT]   = s_q.pflag;
				rd[wdtb_pkg::STAT_ACTIVE_BIT]  = (s_q.st == wdtb_pkg::WDTB_RUN);
				rd[wdtb_pkg::STAT_HOLD_BIT]    = (s_q.st == wdtb_pkg::WDTB_HOLD);
				rd[wdtb_pkg::STAT_MODE_LSB+1:wdtb_pkg::STAT_MODE_LSB] = wdt_mode_cfg;
			end
			wdtb_pkg::ADDR_IRQ_STAT:
				rd[wdtb_pkg::IRQ_W-1:0] = s_q.irq_stat;
			wdtb_pkg::ADDR_IRQ_MASK:
				rd[wdtb_pkg::IRQ_W-1:0] = s_q.irq_mask;
			wdtb_pkg::ADDR_COUNT:
				rd[CNT_W-1:0] = s_q.cnt;
			default:
				rd = 32'h0000_0000;
		endcase

		if (acc && !s_q.pready)
		begin
			s_d.pready  = 1'b1;
			s_d.pslverr = ~wdtb_mapped(paddr);
			s_d.prdata  = pwrite ? 32'h0000_0000 : rd;
		end

		// Writes and read side effects take place at the completing edge.
		if (done)
		begin
			if (pwrite && paddr == wdtb_pkg::ADDR_CTRL)
				s_d.ctrl = pwdata[7:0] & wdtb_pkg::CTRL_WR_MASK;
			if (pwrite && paddr == wdtb_pkg::ADDR_IRQ_MASK)
				s_d.irq_mask = pwdata[wdtb_pkg::IRQ_W-1:0];
			if (!pwrite && paddr == wdtb_pkg::ADDR_IRQ_STAT)
				s_d.irq_stat = '0;
		end

		// Counter control; the tick arrives through the synchroniser.
		clr = clear_watchdog_instr | sleep_edge | osc_fail | osc_startup_timer_running |
			~active;

		case (s_q.st)
			wdtb_pkg::WDTB_OFF,
			wdtb_pkg::WDTB_RUN,
			wdtb_pkg::WDTB_HOLD:
			begin
				if (!active)
					s_d.st = wdtb_pkg::WDTB_OFF;
				else if (osc_startup_timer_running)
					s_d.st = wdtb_pkg::WDTB_HOLD;
				else
					s_d.st = wdtb_pkg::WDTB_RUN;
			end
			default:
				s_d.st = wdtb_pkg::WDTB_OFF;
		endcase

		// Clock switches do not appear here, so they never touch the count.
		if (clr)
			s_d.cnt = '0;
		else if (tick)
		begin
			if (s_q.cnt >= term - {{(CNT_W-1){1'b0}}, 1'b1})
			begin
				s_d.cnt = '0;
				tout    = 1'b1;
			end
			else
				s_d.cnt = s_q.cnt + {{(CNT_W-1){1'b0}}, 1'b1};
		end

		// Flags are cleared by the clear instruction; a new event wins.
		if (clear_watchdog_instr)
		begin
			s_d.tflag = 1'b0;
			s_d.pflag = 1'b0;
		end
		if (sleep_mode && !s_q.sleep_prev)
			s_d.pflag = 1'b1;

		if (tout)
		begin
			s_d.tflag = 1'b1;
			if (sleep_mode || idle_mode)
			begin
				s_d.wake = 1'b1;
				if (sleep_mode)
				begin
					ev[wdtb_pkg::IRQ_WAKE_BIT] = 1'b1;
					s_d.pflag = 1'b1;
				end
			end
			else
			begin
				s_d.rst_req = 1'b1;
				ev[wdtb_pkg::IRQ_RESET_BIT] = 1'b1;
			end
		end

		if (osc_fail)
			ev[wdtb_pkg::IRQ_OSCFAIL_BIT] = 1'b1;

		// Sticky events: a set in the clearing cycle survives.
		s_d.irq_stat = s_d.irq_stat | ev;
		s_d.irq      = |(s_d.irq_stat & s_d.irq_mask);
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s_q            <= '0;
			s_q.st         <= wdtb_pkg::WDTB_OFF;
			s_q.ctrl       <= wdtb_pkg::CTRL_RESET;
			s_q.irq_mask   <= wdtb_pkg::IRQ_MASK_RESET;
		end
		else
			s_q <= s_d;
	end

	assign prdata           = s_q.prdata;
	assign pready           = s_q.pready;
	assign pslverr          = s_q.pslverr;
	assign device_reset_req = s_q.rst_req;
	assign wake_req         = s_q.wake;
	assign timeout_flag     = s_q.tflag;
	assign powerdown_flag   = s_q.pflag;
	assign irq              = s_q.irq;

endmodule

// ===== tb/wdtb_checker.sv
// Port assertions for the watchdog timer block.
module wdtb_checker
#(
	parameter int CNT_W = 24
)
(
	// Clock and reset.
	input wire logic       clk,
	input wire logic       rst,
	// CPU state.
	input wire logic [1:0] wdt_mode_cfg,
	input wire logic       clear_watchdog_instr,
	input wire logic       sleep_mode,
	input wire logic       idle_mode,
	input wire logic       osc_startup_timer_running,
	// Results.
	input wire logic       device_reset_req,
	input wire logic       wake_req,
	input wire logic       timeout_flag,
	input wire logic       powerdown_flag,
	input wire logic       irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	property p_rst_awake;
		device_reset_req |-> !$past(sleep_mode) && !$past(idle_mode);
	endproperty
	a_rst_awake: assert property (p_rst_awake) else $error("reset while asleep");
	property p_wake_why;
		wake_req |-> $past(sleep_mode) || $past(idle_mode);
	endproperty
	a_wake_why: assert property (p_wake_why) else $error("wake while awake");
	property p_off_mode;
		$past(wdt_mode_cfg, 2) == 2'h0 && $past(wdt_mode_cfg) == 2'h0 |-> !device_reset_req && !wake_req;
	endproperty
	a_off_mode: assert property (p_off_mode) else $error("time-out when off");
	property p_sleep_off;
		$past(sleep_mode) && $past(wdt_mode_cfg) == 2'h2 && $past(wdt_mode_cfg, 2) == 2'h2 |-> !wake_req;
	endproperty
	a_sleep_off: assert property (p_sleep_off) else $error("time-out in sleep");
	property p_ost_hold;
		osc_startup_timer_running [*3] |-> !device_reset_req && !wake_req;
	endproperty
	a_ost_hold: assert property (p_ost_hold) else $error("time-out in start-up");
	property p_clr_hold;
		clear_watchdog_instr [*3] |-> !device_reset_req && !wake_req;
	endproperty
	a_clr_hold: assert property (p_clr_hold) else $error("time-out during clear");
	property p_to_flag;
		device_reset_req || wake_req |-> ##[0:1] timeout_flag;
	endproperty
	a_to_flag: assert property (p_to_flag) else $error("time-out flag missing");
	property p_pd_flag;
		wake_req && $past(sleep_mode) |-> ##[0:1] powerdown_flag;
	endproperty
	a_pd_flag: assert property (p_pd_flag) else $error("power-down flag missing");
	c_rst: cover property (device_reset_req);
	c_wake: cover property (wake_req && $past(idle_mode));
	c_irq: cover property (irq);
endmodule

bind wdtb_top wdtb_checker #(.CNT_W(CNT_W)) u_chk
(
	.clk(clk), .rst(rst), .wdt_mode_cfg(wdt_mode_cfg), .clear_watchdog_instr(clear_watchdog_instr),
	.sleep_mode(sleep_mode), .idle_mode(idle_mode), .irq(irq),
	.osc_startup_timer_running(osc_startup_timer_running), .device_reset_req(device_reset_req),
	.wake_req(wake_req), .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag)
);

// ===== tb/wdtb_osc_model.sv
// Low-frequency oscillator model that also counts its rising edges.
module wdtb_osc_model
#(
	parameter int HALF = 4
)
(
	// Clock.
	input  wire logic clk,
	// Oscillator level and rising edges so far.
	output logic      osc,
	output int        rises
);
	timeunit 1ns;
	timeprecision 1ps;
	int div_q;

	initial
	begin
		osc = 1'b0;
		rises = 0;
		div_q = 0;
	end
	// Free-running slow clock, scaled down to keep runs short.
	always @(posedge clk)
	begin
		div_q <= (div_q == HALF - 1) ? 0 : div_q + 1;
		if (div_q == HALF - 1)
		begin
			osc <= ~osc;
			rises <= rises + (osc ? 0 : 1);
		end
	end
endmodule

// ===== tb/tb.sv
// Self-checking bench for the watchdog timer block.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [1:0]  mode = 2'h0;
	logic        clr = 1'b0;
	logic [3:0]  st = 4'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic        pready;
	logic        pslverr;
	logic        err;
	logic        osc;
	logic        dev_rst;
	logic        wake;
	logic        to_flag;
	logic        pd_flag;
	logic        irq;
	int          rises;
	int          fails = 0;
	int          compares = 0;

	always #2 clk = ~clk;

	wdtb_osc_model u_osc (.clk(clk), .osc(osc), .rises(rises));
	wdtb_top dut
	(
		.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .low_freq_internal_osc(osc), .wdt_mode_cfg(mode),
		.clear_watchdog_instr(clr), .sleep_mode(st[3]), .idle_mode(st[2]),
		.osc_startup_timer_running(st[1]), .osc_fail(st[0]), .device_reset_req(dev_rst),
		.wake_req(wake), .timeout_flag(to_flag), .powerdown_flag(pd_flag), .irq(irq)
	);

	task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic test_done();
		if (fails == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			check("pready", pready, 1);
			test_done();
		end
	endtask

	// Sets mode, control and CPU state, clears, then waits for a time-out.
	task automatic run(input logic [1:0] m, input logic [7:0] c, input logic [3:0] s,
		input logic [1:0] e, input int n);
		int k;
		int r0;
		logic [1:0] got;
		apb(1'b1, wdtb_pkg::ADDR_CTRL, {24'h0, c});
		mode <= m;
		st <= s;
		clr <= 1'b1;
		repeat (3) @(posedge clk);
		clr <= 1'b0;
		r0 = rises;
		k = 0;
		got = 2'h0;
		while (got === 2'h0 && k < 1200)
		begin
			@(posedge clk);
			got = {wake, dev_rst};
			k++;
		end
		check("pulse", got, e);
		if (e != 2'h0 && got === 2'h0)
			test_done();
		if (e != 2'h0)
			check("period", (rises - r0 >= n - 1) && (rises - r0 <= n), 1);
		st <= 4'h0;
		repeat (2) @(posedge clk);
	endtask

	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, wdtb_pkg::ADDR_CTRL, 32'h0);
		check("ctrl", rd, 32'h16);
		apb(1'b1, wdtb_pkg::ADDR_CTRL, 32'hffffffff);
		apb(1'b0, wdtb_pkg::ADDR_CTRL, 32'h0);
		check("ctrl", rd, 32'h3f);
		apb(1'b0, 12'h020, 32'h0);
		check("pslverr", err, 1);
		run(2'h3, 8'h00, 4'h0, 2'h1, 32);
		check("timeout_flag", to_flag, 1);
		check("irq", irq, 0);
		apb(1'b0, wdtb_pkg::ADDR_STATUS, 32'h0);
		check("status", rd, 32'h35);
		apb(1'b1, wdtb_pkg::ADDR_IRQ_MASK, 32'h7);
		run(2'h3, 8'h02, 4'h0, 2'h1, 64);
		check("irq", irq, 1);
		apb(1'b0, wdtb_pkg::ADDR_IRQ_STAT, 32'h0);
		check("irq_stat", rd, 32'h1);
		repeat (2) @(posedge clk);
		check("irq", irq, 0);
		run(2'h3, 8'h26, 4'h0, 2'h1, 32);
		run(2'h3, 8'h3e, 4'h0, 2'h1, 32);
		run(2'h3, 8'h00, 4'h8, 2'h2, 32);
		check("powerdown_flag", pd_flag, 1);
		run(2'h2, 8'h00, 4'h0, 2'h1, 32);
		run(2'h2, 8'h00, 4'h8, 2'h0, 32);
		apb(1'b0, wdtb_pkg::ADDR_IRQ_STAT, 32'h0);
		check("irq_stat", rd, 32'h3);
		run(2'h2, 8'h00, 4'h4, 2'h2, 32);
		check("irq", irq, 0);
		apb(1'b0, wdtb_pkg::ADDR_IRQ_STAT, 32'h0);
		check("irq_stat", rd, 32'h0);
		run(2'h1, 8'h01, 4'h8, 2'h2, 32);
		run(2'h1, 8'h00, 4'h0, 2'h0, 32);
		run(2'h0, 8'h01, 4'h0, 2'h0, 32);
		run(2'h3, 8'h00, 4'h2, 2'h0, 32);
		run(2'h3, 8'h00, 4'h1, 2'h0, 32);
		test_done();
	end
endmodule
